// >>> core/rtctc_pkg.sv
// constants and types shared by the rtc time counter block
package rtctc_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam logic [14:0] DIV_LAST = 15'h7fff;
    localparam int unsigned ALARM_DELAY_NS = 61_000;
    localparam int unsigned ALARM_DELAY_CYC = (ALARM_DELAY_NS * (CLK_HZ / 1_000_000)) / 1000;
    localparam logic [10:0] ALARM_DLY_LAST = 11'(ALARM_DELAY_CYC - 1);
    localparam int unsigned HALT_TIME_US = 1000;
    localparam int unsigned HALT_CYC = HALT_TIME_US * (CLK_HZ / 1_000_000);

    // ----------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    typedef logic [3:0] rtctc_idx_t;
    localparam rtctc_idx_t IDX_SEC = 4'h0;
    localparam rtctc_idx_t IDX_MIN = 4'h1;
    localparam rtctc_idx_t IDX_HOUR = 4'h2;
    localparam rtctc_idx_t IDX_WDAY = 4'h3;
    localparam rtctc_idx_t IDX_CTRL1 = 4'he;
    localparam rtctc_idx_t IDX_CTRL2 = 4'hf;

    // ----------------------------------------------------------------
    // field positions and reset values
    // ----------------------------------------------------------------
    localparam int unsigned C1_WEEKLY_ALARM_ENABLE = 7;
    localparam int unsigned C1_DAILY_ALARM_ENABLE = 6;
    localparam int unsigned C1_MODE24 = 5;
    localparam int unsigned C1_CLKDIS2 = 4;
    localparam int unsigned C2_SCRATCH1 = 5;
    localparam int unsigned C2_HALT = 4;
    localparam int unsigned C2_CLKDIS1 = 3;
    localparam int unsigned C2_PFLAG = 2;
    localparam int unsigned C2_WFLAG = 1;
    localparam int unsigned C2_DFLAG = 0;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h10;

    // periodic output selection, ctrl1[2:0]
    localparam logic [2:0] PSEL_OFF = 3'h0;
    localparam logic [2:0] PSEL_LOW = 3'h1;
    localparam logic [2:0] PSEL_2HZ = 3'h2;
    localparam logic [2:0] PSEL_1HZ = 3'h3;
    localparam logic [2:0] PSEL_SEC = 3'h4;
    localparam logic [2:0] PSEL_MIN = 3'h5;
    localparam logic [2:0] PSEL_HOUR = 3'h6;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// >>> core/rtctc_time.sv
// bcd seconds, minutes, hours and weekday_count chain
`timescale 1ns/10ps
module rtctc_time (
    input wire logic clk,
    input wire logic resetn,
    input wire logic sec_tick,
    input wire logic wr_en,
    input wire rtctc_pkg::rtctc_idx_t wr_idx,
    input wire logic [7:0] wr_data,
    input wire logic mode24,
    output logic [6:0] seconds,
    output logic [6:0] minutes,
    output logic [5:0] hours,
    output logic [2:0] weekday,
    output logic min_carry,
    output logic hour_carry,
    output logic day_carry
);
    import rtctc_pkg::*;

    typedef struct packed {
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hr;
        logic [2:0] wd;
        logic cm;
        logic ch;
        logic cd;
    } rtctc_time_st_t;

    rtctc_time_st_t s;
    rtctc_time_st_t next_s;
    logic [6:0] hr_next;

    function automatic logic [6:0] bcd_inc(input logic [6:0] v);
        if (v[3:0] == 4'h9) begin
            bcd_inc = {v[6:4] + 3'h1, 4'h0};
        end else begin
            bcd_inc = {v[6:4], v[3:0] + 4'h1};
        end
    endfunction

    // returns {day carry, next hour}
    function automatic logic [6:0] next_hour(input logic [5:0] h, input logic m24);
        logic [6:0] inc;
        inc = bcd_inc({1'b0, h});
        if (m24) begin
            next_hour = (h == 6'h23) ? 7'h40 : {1'b0, inc[5:0]};
        end else if (h[4:0] == 5'h12) begin
            next_hour = {1'b0, h[5], 5'h01};
        end else if (h[4:0] == 5'h11) begin
            next_hour = {h[5], ~h[5], 5'h12};
        end else begin
            next_hour = {1'b0, h[5], inc[4:0]};
        end
    endfunction

    always_comb begin
        next_s = s;
        next_s.cm = 1'b0;
        next_s.ch = 1'b0;
        next_s.cd = 1'b0;
        hr_next = next_hour(s.hr, mode24);
        if (sec_tick) begin
            if (s.sec == 7'h59) begin
                next_s.sec = 7'h00;
                next_s.cm = 1'b1;
                if (s.min == 7'h59) begin
                    next_s.min = 7'h00;
                    next_s.ch = 1'b1;
                    next_s.hr = hr_next[5:0];
                    if (hr_next[6]) begin
                        next_s.cd = 1'b1;
                        next_s.wd = (s.wd == 3'h6) ? 3'h0 : s.wd + 3'h1;
                    end
                end else begin
                    next_s.min = bcd_inc(s.min);
                end
            end else begin
                next_s.sec = bcd_inc(s.sec);
            end
        end
        if (wr_en) begin
            case (wr_idx)
                IDX_SEC: next_s.sec = wr_data[6:0];
                IDX_MIN: next_s.min = wr_data[6:0];
                IDX_HOUR: next_s.hr = wr_data[5:0];
                IDX_WDAY: next_s.wd = wr_data[2:0];
                default: next_s = next_s;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign seconds = s.sec;
    assign minutes = s.min;
    assign hours = s.hr;
    assign weekday = s.wd;
    assign min_carry = s.cm;
    assign hour_carry = s.ch;
    assign day_carry = s.cd;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sec_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (sec_tick && !wr_en && s.sec == 7'h59) |=> (s.sec == 7'h00 && s.cm))
        else $error("seconds did not wrap to 00 with a carry");
    min_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (sec_tick && !wr_en && s.sec == 7'h59 && s.min == 7'h59) |=> (s.min == 7'h00 && s.ch))
        else $error("minutes did not wrap to 00 with a carry");
    hour_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (sec_tick && !wr_en && mode24 && s.sec == 7'h59 && s.min == 7'h59 && s.hr == 6'h23)
            |=> (s.hr == 6'h00 && s.cd))
        else $error("hours did not wrap from 23 to 00 with a day carry");
    wday_wrap_a: assert property (@(posedge clk) disable iff (!resetn)
        (s.cd && $past(s.wd) == 3'h6) |-> s.wd == 3'h0)
        else $error("weekday did not wrap from 6 to 0");

endmodule

// >>> core/rtctc_top.sv
// rtc time counters, control flags and ahb-lite register slave
`timescale 1ns/10ps
module rtctc_top #(
    parameter int unsigned HALT_CYCLES = rtctc_pkg::HALT_CYC,
    parameter bit CLKOUT_CTRL = 1'b1
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic crystal_clk,
    input wire logic weekly_alarm_hit,
    input wire logic daily_alarm_hit,
    output logic irq_out_n,
    output logic crystal_clock_out
);
    import rtctc_pkg::*;

    localparam logic [19:0] HALT_LIMIT = 20'(HALT_CYCLES);
    // window for the tail of the alarm countdown, checked from count 999
    localparam int DLY_MAX = 1000;

    typedef struct packed {
        logic xs1;
        logic xs2;
        logic xs3;
        logic [1:0] as1;
        logic [1:0] as2;
        logic [1:0] as3;
        logic [14:0] div;
        logic tick;
        logic [19:0] hcnt;
        logic [7:0] ctrl1;
        logic scratch1;
        logic halt;
        logic clkout_disable_first;
        logic pflag;
        logic [1:0] aflag;
        logic [1:0] dly_on;
        logic [1:0][10:0] dly;
        logic wpend;
        rtctc_idx_t widx;
        logic [31:0] rdata;
        logic rdy;
        logic resp;
        logic irq_n;
        logic clkout;
    } rtctc_top_st_t;

    localparam rtctc_top_st_t RST_STATE = '{
        halt: CTRL2_RST[C2_HALT], irq_n: 1'b1, clkout: 1'b1, rdy: 1'b1,
        ctrl1: CTRL1_RST, default: '0};

    rtctc_top_st_t s;
    rtctc_top_st_t next_s;
    logic edge_x;
    logic halt_evt;
    logic lvl_evt;
    logic [1:0] alarm_en;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic [6:0] seconds;
    logic [6:0] minutes;
    logic [5:0] hours;
    logic [2:0] weekday;
    logic min_carry;
    logic hour_carry;
    logic day_carry;

    // ----------------------------------------------------------------
    // address decode
    // ----------------------------------------------------------------
    function automatic rtctc_idx_t addr_idx(input logic [31:0] a);
        addr_idx = a[5:2];
    endfunction

    function automatic logic addr_ok(input logic [31:0] a);
        rtctc_idx_t i;
        i = addr_idx(a);
        addr_ok = (a[31:6] == 26'h0) && (a[1:0] == 2'h0)
            && (i[3:2] == 2'h0 || i == IDX_CTRL1 || i == IDX_CTRL2);
    endfunction

    // ----------------------------------------------------------------
    // counter chain
    // ----------------------------------------------------------------
    rtctc_time u_time (
        .clk(clk),
        .resetn(resetn),
        .sec_tick(s.tick),
        .wr_en(s.wpend && s.widx[3:2] == 2'h0),
        .wr_idx(s.widx),
        .wr_data(hwdata[7:0]),
        .mode24(s.ctrl1[C1_MODE24]),
        .seconds(seconds),
        .minutes(minutes),
        .hours(hours),
        .weekday(weekday),
        .min_carry(min_carry),
        .hour_carry(hour_carry),
        .day_carry(day_carry)
    );

    // ----------------------------------------------------------------
    // read mux
    // ----------------------------------------------------------------
    always_comb begin
        alarm_en = {s.ctrl1[C1_WEEKLY_ALARM_ENABLE], s.ctrl1[C1_DAILY_ALARM_ENABLE]};
        case (addr_idx(haddr))
            IDX_SEC: rd_byte = {1'b0, seconds};
            IDX_MIN: rd_byte = {1'b0, minutes};
            IDX_HOUR: rd_byte = {2'b00, hours};
            IDX_WDAY: rd_byte = {5'h00, weekday};
            IDX_CTRL1: rd_byte = s.ctrl1;
            IDX_CTRL2: rd_byte = {2'b00, s.scratch1, s.halt, s.clkout_disable_first,
                s.pflag, s.aflag & alarm_en};
            default: rd_byte = 8'h00;
        endcase
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        wd = hwdata[7:0];
        edge_x = s.xs2 & ~s.xs3;
        halt_evt = 1'b0;
        next_s.xs1 = crystal_clk;
        next_s.xs2 = s.xs1;
        next_s.xs3 = s.xs2;
        next_s.as1 = {weekly_alarm_hit, daily_alarm_hit};
        next_s.as2 = s.as1;
        next_s.as3 = s.as2;
        next_s.tick = 1'b0;
        next_s.rdy = 1'b1;
        next_s.resp = 1'b0;

        // sub-second divider on crystal edges
        if (edge_x) begin
            next_s.div = s.div + 15'h1;
            next_s.tick = (s.div == DIV_LAST);
        end

        // halt watchdog: no crystal edge for the limit
        if (edge_x) begin
            next_s.hcnt = 20'h0;
        end else if (s.hcnt != HALT_LIMIT) begin
            next_s.hcnt = s.hcnt + 20'h1;
            halt_evt = (s.hcnt == HALT_LIMIT - 20'h1);
        end

        // address phase
        next_s.wpend = 1'b0;
        if (hsel && htrans[1] && hready) begin
            next_s.widx = addr_idx(haddr);
            next_s.wpend = hwrite && addr_ok(haddr);
            if (!hwrite) begin
                next_s.rdata = addr_ok(haddr) ? {24'h0, rd_byte} : 32'h0;
            end
        end

        // data phase writes
        if (s.wpend) begin
            case (s.widx)
                IDX_SEC: begin
                    next_s.div = 15'h0;
                    next_s.tick = 1'b0;
                end
                IDX_CTRL1: next_s.ctrl1 = wd;
                IDX_CTRL2: begin
                    next_s.scratch1 = wd[C2_SCRATCH1];
                    next_s.clkout_disable_first = wd[C2_CLKDIS1];
                    if (!wd[C2_HALT]) begin
                        next_s.halt = 1'b0;
                    end
                    if (!wd[C2_PFLAG] && s.ctrl1[2]) begin
                        next_s.pflag = 1'b0;
                    end
                    if (!wd[C2_WFLAG]) begin
                        next_s.aflag[1] = 1'b0;
                    end
                    if (!wd[C2_DFLAG]) begin
                        next_s.aflag[0] = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // alarm match delay, then flag; set wins over clear
        for (int i = 0; i < 2; i++) begin
            if (!alarm_en[i]) begin
                next_s.aflag[i] = 1'b0;
            end
            if (s.as2[i] && !s.as3[i]) begin
                next_s.dly_on[i] = 1'b1;
                next_s.dly[i] = ALARM_DLY_LAST;
            end else if (s.dly_on[i]) begin
                if (s.dly[i] == 11'h0) begin
                    next_s.dly_on[i] = 1'b0;
                    if (alarm_en[i]) begin
                        next_s.aflag[i] = 1'b1;
                    end
                end else begin
                    next_s.dly[i] = s.dly[i] - 11'h1;
                end
            end
        end

        // periodic output
        case (s.ctrl1[2:0])
            PSEL_SEC: lvl_evt = s.tick;
            PSEL_MIN: lvl_evt = min_carry;
            PSEL_HOUR: lvl_evt = hour_carry;
            default: lvl_evt = day_carry;
        endcase
        case (s.ctrl1[2:0])
            PSEL_OFF: next_s.pflag = 1'b0;
            PSEL_LOW: next_s.pflag = 1'b1;
            PSEL_2HZ: next_s.pflag = ~s.div[13];
            PSEL_1HZ: next_s.pflag = ~s.div[14];
            default: begin
                if (lvl_evt) begin
                    next_s.pflag = 1'b1;
                end
            end
        endcase

        // oscillation halt forces defaults
        if (halt_evt) begin
            next_s.halt = 1'b1;
            next_s.ctrl1 = CTRL1_RST;
            next_s.scratch1 = 1'b0;
            next_s.clkout_disable_first = 1'b0;
            next_s.pflag = 1'b0;
            next_s.aflag = 2'b00;
            next_s.dly_on = 2'b00;
        end

        // pins follow their flags in the same cycle
        next_s.irq_n = ~(next_s.pflag | (|next_s.aflag));
        if (CLKOUT_CTRL && next_s.clkout_disable_first && next_s.ctrl1[C1_CLKDIS2]) begin
            next_s.clkout = 1'b1;
        end else begin
            next_s.clkout = s.xs2;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            s <= RST_STATE;
        end else begin
            s <= next_s;
        end
    end

    assign hreadyout = s.rdy;
    assign hresp = s.resp;
    assign hrdata = s.rdata;
    assign irq_out_n = s.irq_n;
    assign crystal_clock_out = s.clkout;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    clkout_off_a: assert property (
        (CLKOUT_CTRL && s.clkout_disable_first && s.ctrl1[C1_CLKDIS2])
            ##1 (s.clkout_disable_first && s.ctrl1[C1_CLKDIS2]) |-> crystal_clock_out)
        else $error("clock output not held high with both disables set");
    clkout_run_a: assert property (
        (!s.clkout_disable_first && !halt_evt && !(s.wpend && s.widx == IDX_CTRL2
            && hwdata[C2_CLKDIS1] && s.ctrl1[C1_CLKDIS2]))
            |=> crystal_clock_out == $past(s.xs2))
        else $error("clock output not following crystal while enabled");
    scratch_clear_a: assert property (
        halt_evt |=> (!s.clkout_disable_first && !s.scratch1))
        else $error("scratch bits survive oscillation halt");
    pflag_set_a: assert property (
        (s.ctrl1[2] && lvl_evt && !halt_evt) |=> (s.pflag && !irq_out_n))
        else $error("periodic event did not set flag and pull pin low");
    pflag_clear_a: assert property (
        (s.wpend && s.widx == IDX_CTRL2 && !hwdata[C2_PFLAG] && s.ctrl1[2] && !lvl_evt
            && !halt_evt && s.aflag == 2'b00 && s.as2 == s.as3 && s.dly_on == 2'b00)
            |=> (!s.pflag && irq_out_n))
        else $error("zero write did not release periodic flag");
    alarm_delay_a: assert property (
        (s.dly_on[1] && s.dly[1] == 11'h3e7 && s.ctrl1[C1_WEEKLY_ALARM_ENABLE]) ##1 s.ctrl1[C1_WEEKLY_ALARM_ENABLE] [*8]
            |-> ##[1:DLY_MAX] (s.aflag[1] || !s.ctrl1[C1_WEEKLY_ALARM_ENABLE] || s.halt
                || s.dly[1] > 11'h3e7))
        else $error("weekly alarm flag not set after match delay");
    alarm_load_a: assert property (
        (s.as2[1] && !s.as3[1] && !halt_evt) |=> (s.dly_on[1] && s.dly[1] == ALARM_DLY_LAST))
        else $error("alarm match did not load the full delay");
    alarm_clear_a: assert property (
        (s.wpend && s.widx == IDX_CTRL2 && !hwdata[C2_DFLAG] && !s.dly_on[0])
            |=> !s.aflag[0])
        else $error("zero write did not clear daily alarm flag");
    alarm_mask_a: assert property (
        !s.ctrl1[C1_DAILY_ALARM_ENABLE] |=> !s.aflag[0])
        else $error("disabled alarm flag not zero");
    div_reset_a: assert property (
        (s.wpend && s.widx == IDX_SEC) |=> (s.div == 15'h0 && !s.tick))
        else $error("seconds write did not reset divider");
    halt_sticky_a: assert property (
        (s.halt && !(s.wpend && s.widx == IDX_CTRL2 && !hwdata[C2_HALT])) |=> s.halt)
        else $error("halt flag dropped without a zero write");
    halt_defaults_a: assert property (
        halt_evt |=> (s.ctrl1 == 8'h00 && s.halt && !s.pflag && irq_out_n))
        else $error("halt did not restore control defaults");
    wday_read_a: assert property (
        (hsel && htrans[1] && hready && !hwrite && haddr == 32'h0000000c)
            |=> hrdata[31:3] == 29'h0)
        else $error("weekday upper bits not zero");

    level_irq_c: cover property (s.ctrl1[2:0] == PSEL_SEC && $fell(irq_out_n));
    alarm_irq_c: cover property ($rose(s.aflag[1]));
    halt_c: cover property (halt_evt ##[1:50] (s.wpend && s.widx == IDX_CTRL2));
    pulse_c: cover property (s.ctrl1[2:0] == PSEL_2HZ && $rose(irq_out_n));

endmodule

// >>> tb/rtctc_xtal.sv
// crystal oscillator model feeding the rtc block
`timescale 1ns/10ps
module rtctc_xtal (
    input wire logic run,
    output logic crystal_clk
);
    // ------------------------------------------------------------
    // 400 ns crystal, frozen while run is low to fake a halt
    // ------------------------------------------------------------
    initial begin
        crystal_clk = 1'b0;
    end
    always begin
        #200;
        if (run) begin
            crystal_clk = ~crystal_clk;
        end
    end
endmodule

// >>> tb/rtctc_top_bench.sv
// self-checking bench for the rtc time counter block
`timescale 1ns/10ps
module rtctc_top_bench;
    import rtctc_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic [31:0] hrdata;
    logic irq_out_n;
    logic crystal_clock_out;
    logic crystal_clk;
    logic xtal_run = 1'b1;
    logic weekly_alarm_hit = 1'b0;
    logic daily_alarm_hit = 1'b0;
    logic [31:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;

    assign hready = hreadyout;
    always #25 clk = ~clk;

    rtctc_top #(.HALT_CYCLES(64), .CLKOUT_CTRL(1'b1)) u_rtctc_top (
        .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(HSIZE_WORD), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .crystal_clk(crystal_clk),
        .weekly_alarm_hit(weekly_alarm_hit), .daily_alarm_hit(daily_alarm_hit),
        .irq_out_n(irq_out_n), .crystal_clock_out(crystal_clock_out)
    );
    rtctc_xtal u_rtctc_xtal (.run(xtal_run), .crystal_clk(crystal_clk));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input rtctc_idx_t idx, input logic wr, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {26'h0, idx, 2'h0};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        check({31'h0, hresp}, 32'h0);
    endtask
    task automatic wr(input rtctc_idx_t idx, input logic [7:0] wd);
        bus(idx, 1'b1, wd);
    endtask
    task automatic rdc(input rtctc_idx_t idx, input logic [31:0] exp);
        bus(idx, 1'b0, 8'h00);
        check(rd, exp);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(IDX_CTRL2, 32'h1 << C2_HALT);
        rdc(IDX_CTRL1, 32'h0);
        check({31'h0, irq_out_n}, 32'h1);
    endtask
    task automatic t_halt();
        wr(IDX_CTRL2, 8'h10);
        rdc(IDX_CTRL2, 32'h10);
        wr(IDX_CTRL2, 8'h00);
        rdc(IDX_CTRL2, 32'h0);
        wr(IDX_CTRL2, 8'h20);
        wr(IDX_CTRL1, 8'h80);
        xtal_run = 1'b0;
        repeat (120) @(posedge clk);
        rdc(IDX_CTRL2, 32'h10);
        rdc(IDX_CTRL1, 32'h0);
        xtal_run = 1'b1;
        repeat (40) @(posedge clk);
        rdc(IDX_CTRL2, 32'h10);
        wr(IDX_CTRL2, 8'h00);
    endtask
    task automatic t_counters();
        wr(IDX_CTRL1, 8'h01 << C1_MODE24);
        wr(IDX_SEC, 8'hd9);
        rdc(IDX_SEC, 32'h59);
        wr(IDX_MIN, 8'hd9);
        rdc(IDX_MIN, 32'h59);
        wr(IDX_HOUR, 8'he3);
        rdc(IDX_HOUR, 32'h23);
        wr(IDX_WDAY, 8'hfe);
        rdc(IDX_WDAY, 32'h06);
        wr(4'h4, 8'h55);
        rdc(4'h4, 32'h0);
    endtask
    task automatic t_clkout();
        int lows;
        for (int k = 0; k < 4; k++) begin
            wr(IDX_CTRL1, 8'(k & 1) << C1_CLKDIS2);
            wr(IDX_CTRL2, 8'(k >> 1) << C2_CLKDIS1);
            repeat (8) @(posedge clk);
            lows = 0;
            repeat (40) begin
                @(posedge clk);
                if (crystal_clock_out !== 1'b1) lows++;
            end
            check({31'h0, lows == 0}, {31'h0, k == 3});
        end
        wr(IDX_CTRL1, 8'h00);
        wr(IDX_CTRL2, 8'h00);
    endtask
    task automatic t_alarm();
        wr(IDX_CTRL1, 8'h01 << C1_WEEKLY_ALARM_ENABLE);
        @(posedge clk);
        weekly_alarm_hit <= 1'b1;
        daily_alarm_hit <= 1'b1;
        repeat (1150) @(posedge clk);
        rdc(IDX_CTRL2, 32'h0);
        repeat (80) @(posedge clk);
        rdc(IDX_CTRL2, 32'h1 << C2_WFLAG);
        check({31'h0, irq_out_n}, 32'h0);
        wr(IDX_CTRL2, 8'h03);
        rdc(IDX_CTRL2, 32'h1 << C2_WFLAG);
        wr(IDX_CTRL2, 8'h00);
        rdc(IDX_CTRL2, 32'h0);
        check({31'h0, irq_out_n}, 32'h1);
        weekly_alarm_hit <= 1'b0;
        daily_alarm_hit <= 1'b0;
        wr(IDX_CTRL1, 8'h00);
    endtask
    task automatic t_periodic();
        wr(IDX_CTRL1, {5'h0, PSEL_LOW});
        rdc(IDX_CTRL2, 32'h1 << C2_PFLAG);
        check({31'h0, irq_out_n}, 32'h0);
        wr(IDX_CTRL1, {5'h0, PSEL_OFF});
        rdc(IDX_CTRL2, 32'h0);
        check({31'h0, irq_out_n}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            final_report();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_halt();
        t_counters();
        t_clkout();
        t_alarm();
        t_periodic();
        final_report();
    end
endmodule
